/* psr_status_regs.sv */
// paged status readout bank with wishbone slave and interrupt
`default_nettype none
`include "psr_consts.svh"

module psr_status_regs #(
  parameter int ADC_CYCLES = `PSR_ADC_CYCLES
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // front end
  input wire psr_pkg::psr_fe_t i_fe,
  output logic o_adc_start,
  output psr_pkg::psr_agl_t o_agl,
  // interrupt
  output logic o_irq
);
  import psr_pkg::*;

  localparam logic [11:0] ADC_LAST = 12'(ADC_CYCLES - 1);

  function automatic logic [3:0] nib_max(input logic [3:0] a,
                                         input logic [3:0] b);
    nib_max = (a > b) ? a : b;
  endfunction

  function automatic logic [2:0] agl_clamp(input logic [2:0] code);
    agl_clamp = (code > `PSR_AGL_MAX) ? `PSR_AGL_MAX : code;
  endfunction

  // ************************************************************
  // input synchronisers
  // ************************************************************
  // multi-bit values are sampled per bit; a value changing at the sample
  // edge may read one cycle mixed, which the analog side tolerates
  psr_fe_t fe_m_q;
  psr_fe_t fe_s_q;
  psr_fe_t fe_p_q;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fe_m_q <= '0;
      fe_s_q <= '0;
      fe_p_q <= '0;
    end else begin
      fe_m_q <= i_fe;
      fe_s_q <= fe_m_q;
      fe_p_q <= fe_s_q;
    end
  end

  wire logic rx_rise = fe_s_q.rx_active & ~fe_p_q.rx_active;
  wire logic bit_rise = fe_s_q.rx_bit & ~fe_p_q.rx_bit;
  wire logic pilot_rise = fe_s_q.pilot_mark & ~fe_p_q.pilot_mark;
  wire logic data_rise = fe_s_q.data_mark & ~fe_p_q.data_mark;
  wire logic coll_rise = fe_s_q.collision & ~fe_p_q.collision;
  wire logic err_rise = fe_s_q.proto_err & ~fe_p_q.proto_err;
  wire logic [7:0] live_rssi = {fe_s_q.rssi_q, fe_s_q.rssi_i};

  // ************************************************************
  // bus decode
  // ************************************************************
  logic ack_q;
  logic [31:0] dat_q;
  wire logic [5:0] idx = i_wb_adr[7:2];
  wire logic req = i_wb_cyc & i_wb_stb & ~ack_q;
  // writes land only on byte lane 0, where every register sits
  wire logic wr = req & i_wb_we & i_wb_sel[0];
  wire logic rd = req & ~i_wb_we;
  wire logic [7:0] wdat = i_wb_dat[7:0];
  wire logic wr_page = wr & (idx == `PSR_IDX_PAGE);
  wire logic wr_st = wr & (idx == `PSR_IDX_IRQ_ST);
  wire logic wr_mask = wr & (idx == `PSR_IDX_IRQ_MASK);
  wire logic wr_cmd = wr & (idx == `PSR_IDX_CMD);
  wire logic cmd_store = wr_cmd & (wdat == `PSR_CMD_STORE_RSSI);
  wire logic cmd_adc = wr_cmd & (wdat == `PSR_CMD_ADC);

  // ************************************************************
  // page select and snapshots
  // ************************************************************
  logic [7:0] page_q;
  logic [7:0] noise_q;
  logic [7:0] pilot_q;
  logic [7:0] data_q;
  logic [7:0] peak_q;
  logic in_select_q;
  logic [7:0] bit_cnt_q;
  logic [7:0] coll_time_q;
  logic [7:0] coll_len_q;
  logic [7:0] err_time_q;
  logic err_seen_q;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      page_q <= `PSR_PAGE_RESET;
    end else if (wr_page) begin
      page_q <= wdat;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      noise_q <= 8'h00;
      pilot_q <= 8'h00;
      data_q <= 8'h00;
    end else begin
      if (cmd_store) begin
        noise_q <= live_rssi;
      end
      if (pilot_rise) begin
        pilot_q <= live_rssi;
      end
      if (data_rise) begin
        data_q <= live_rssi;
      end
    end
  end

  // peak restarts at each reception and follows each channel's maximum
  wire logic [7:0] peak_d = {nib_max(peak_q[7:4], fe_s_q.rssi_q),
                             nib_max(peak_q[3:0], fe_s_q.rssi_i)};

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      peak_q <= 8'h00;
      in_select_q <= 1'b0;
    end else begin
      if (rx_rise) begin
        peak_q <= live_rssi;
        in_select_q <= fe_s_q.iq_select;
      end else if (fe_s_q.rx_active) begin
        peak_q <= peak_d;
      end
    end
  end

  // timing is counted in received bits, saturating at 255
  wire logic [7:0] bit_cnt_d = (bit_cnt_q == 8'hff) ? bit_cnt_q
                                                     : bit_cnt_q + 8'h01;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bit_cnt_q <= 8'h00;
      coll_time_q <= 8'h00;
      coll_len_q <= 8'h00;
      err_time_q <= 8'h00;
      err_seen_q <= 1'b0;
    end else if (rx_rise) begin
      bit_cnt_q <= 8'h00;
      err_seen_q <= 1'b0;
    end else begin
      if (bit_rise) begin
        bit_cnt_q <= bit_cnt_d;
      end
      if (coll_rise) begin
        coll_time_q <= bit_cnt_q;
        coll_len_q <= 8'h00;
      end else if (fe_s_q.collision & bit_rise & coll_len_q != 8'hff) begin
        coll_len_q <= coll_len_q + 8'h01;
      end
      if (err_rise & ~err_seen_q) begin
        err_time_q <= bit_cnt_q;
        err_seen_q <= 1'b1;
      end
    end
  end

  // ************************************************************
  // converter sequencing
  // ************************************************************
  psr_adc_state_t adc_state_q;
  logic [11:0] adc_cnt_q;
  logic [7:0] adc_q;
  wire logic adc_go = cmd_adc & (adc_state_q == PSR_ADC_IDLE);
  wire logic adc_done = (adc_state_q == PSR_ADC_CONV) & (adc_cnt_q == 12'h0);

  // a second trigger during a conversion is ignored, not restarted
  assign o_adc_start = adc_go;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      adc_state_q <= PSR_ADC_IDLE;
      adc_cnt_q <= 12'h0;
      adc_q <= 8'h00;
    end else begin
      case (adc_state_q)
        PSR_ADC_IDLE: begin
          if (adc_go) begin
            adc_state_q <= PSR_ADC_CONV;
            adc_cnt_q <= ADC_LAST;
          end
        end
        PSR_ADC_CONV: begin
          if (adc_done) begin
            adc_q <= fe_s_q.adc_value;
            adc_state_q <= PSR_ADC_IDLE;
          end else begin
            adc_cnt_q <= adc_cnt_q - 12'h1;
          end
        end
        default: begin
          adc_state_q <= PSR_ADC_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // interrupt
  // ************************************************************
  logic [3:0] irq_st_q;
  logic [3:0] irq_mask_q;
  wire logic [3:0] irq_ev = {err_rise & ~err_seen_q, coll_rise,
                             cmd_store, adc_done};
  wire logic [3:0] irq_clr = wr_st ? wdat[3:0] : 4'h0;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_st_q <= `PSR_IRQ_RESET;
      irq_mask_q <= `PSR_IRQ_RESET;
    end else begin
      // a new event outranks a clear in the same cycle
      irq_st_q <= (irq_st_q & ~irq_clr) | irq_ev;
      if (wr_mask) begin
        irq_mask_q <= wdat[3:0];
      end
    end
  end

  assign o_irq = |(irq_st_q & irq_mask_q);

  // ************************************************************
  // read selection
  // ************************************************************
  wire logic [1:0] pg2d = page_q[`PSR_PG2D_HI:`PSR_PG2D_LO];
  wire logic [1:0] pg2c = page_q[`PSR_PG2C_HI:`PSR_PG2C_LO];
  wire logic [3:0] pg2b = page_q[`PSR_PG2B_HI:`PSR_PG2B_LO];

  wire logic [7:0] agc_byte = {fe_s_q.subc_phase, fe_s_q.agc_gain,
                               in_select_q, fe_s_q.carrier_stable,
                               fe_s_q.pll_locked, fe_s_q.osc_stable};

  // upper nibble Q, lower nibble I in the live level and level snapshots; collision and error pages hold bit counts
  wire logic [7:0] rssi_byte =
    (pg2b == `PSR_RSSI_LIVE) ? live_rssi :
    (pg2b == `PSR_RSSI_NOISE) ? noise_q :
    (pg2b == `PSR_RSSI_PILOT) ? pilot_q :
    (pg2b == `PSR_RSSI_DATA) ? data_q :
    (pg2b == `PSR_RSSI_PEAK) ? peak_q :
    (pg2b == `PSR_RSSI_CTIME) ? coll_time_q :
    (pg2b == `PSR_RSSI_CLEN) ? coll_len_q :
    (pg2b == `PSR_RSSI_ETIME) ? err_time_q : 8'h00;

  wire logic [7:0] pg2c_byte =
    (pg2c == `PSR_PG_00) ? {2'b00, fe_s_q.agl_q, fe_s_q.agl_i} :
    (pg2c == `PSR_PG_10) ? {fe_s_q.highpass_cal_value,
                            fe_s_q.lowpass_cal_value} : 8'h00;

  wire logic [7:0] pg2d_byte = (pg2d == `PSR_PG_00) ? adc_q : 8'h00;

  // status addresses take no write
  wire logic [7:0] rd_byte =
    (idx == `PSR_IDX_PAGE) ? page_q :
    (idx == `PSR_IDX_AGC) ? agc_byte :
    (idx == `PSR_IDX_RSSI) ? rssi_byte :
    (idx == `PSR_IDX_PG2C) ? pg2c_byte :
    (idx == `PSR_IDX_PG2D) ? pg2d_byte :
    (idx == `PSR_IDX_IRQ_ST) ? {4'h0, irq_st_q} :
    (idx == `PSR_IDX_IRQ_MASK) ? {4'h0, irq_mask_q} : 8'h00;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      dat_q <= rd ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = dat_q;

  // gain steps above 4 behave as step 4 at the receiver
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_agl <= '0;
    end else begin
      o_agl.q_step <= agl_clamp(fe_s_q.agl_q);
      o_agl.i_step <= agl_clamp(fe_s_q.agl_i);
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  logic [12:0] conv_age_q;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      conv_age_q <= 13'h0;
    end else begin
      conv_age_q <= (adc_state_q == PSR_ADC_CONV) ? conv_age_q + 13'h1
                                                   : 13'h0;
    end
  end

  page2d_read_a: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    rd & idx == `PSR_IDX_PG2D & pg2d == `PSR_PG_00 & ~adc_done
    |=> o_wb_ack && o_wb_dat[7:0] == adc_q)
    else $error("2Dh page 00 read missed converter result");

  page2c_cal_a: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    rd & idx == `PSR_IDX_PG2C & pg2c == `PSR_PG_10
    |=> o_wb_dat[7:0] == $past({fe_s_q.highpass_cal_value,
                                fe_s_q.lowpass_cal_value}))
    else $error("2Ch page 10 read wrong calibration");

  rssi_noise_a: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    rd & idx == `PSR_IDX_RSSI & pg2b == `PSR_RSSI_NOISE
    |=> o_wb_dat[7:0] == $past(noise_q))
    else $error("noise page read wrong value");

  noise_capture_a: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    cmd_store |=> noise_q == $past(live_rssi) && irq_st_q[`PSR_IRQ_NOISE])
    else $error("store command did not capture noise level");

  iq_hold_a: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    !rx_rise |=> $stable(in_select_q))
    else $error("decoding channel changed mid reception");

  rfu_zero_a: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    rd & idx == `PSR_IDX_PG2C & pg2c == `PSR_PG_00
    |=> o_wb_dat[7:6] == 2'b00 && o_wb_dat[5:0] == $past({fe_s_q.agl_q,
                                                          fe_s_q.agl_i}))
    else $error("2Ch page 00 layout wrong");

  agl_clamp_a: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    fe_s_q.agl_q > `PSR_AGL_MAX |=> o_agl.q_step == `PSR_AGL_MAX)
    else $error("gain-limit code above 4 not held at 4");

  adc_time_a: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (conv_age_q <= 13'(ADC_CYCLES)) and
    (adc_done |-> conv_age_q == 13'(ADC_CYCLES - 1)))
    else $error("converter result not after the settle time");

  ro_write_a: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    wr & idx != `PSR_IDX_PAGE |=> $stable(page_q))
    else $error("page select changed by another address");

  irq_set_wins_a: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    adc_done & wr_st & wdat[`PSR_IRQ_ADC] |=> irq_st_q[`PSR_IRQ_ADC])
    else $error("event lost against a clear");

endmodule
`default_nettype wire

/* psr_consts.svh */
// offsets, field positions, codes and timing counts of the paged status bank
`ifndef PSR_CONSTS_SVH
`define PSR_CONSTS_SVH

// register indices; byte address is four times the index
`define PSR_IDX_PAGE 6'h29
`define PSR_IDX_AGC 6'h2a
`define PSR_IDX_RSSI 6'h2b
`define PSR_IDX_PG2C 6'h2c
`define PSR_IDX_PG2D 6'h2d
`define PSR_IDX_IRQ_ST 6'h30
`define PSR_IDX_IRQ_MASK 6'h31
`define PSR_IDX_CMD 6'h32

// page select field positions
`define PSR_PG2D_HI 7
`define PSR_PG2D_LO 6
`define PSR_PG2C_HI 5
`define PSR_PG2C_LO 4
`define PSR_PG2B_HI 3
`define PSR_PG2B_LO 0
`define PSR_PAGE_RESET 8'h00

// signal strength page codes
`define PSR_RSSI_LIVE 4'h0
`define PSR_RSSI_NOISE 4'h2
`define PSR_RSSI_PILOT 4'h4
`define PSR_RSSI_DATA 4'h6
`define PSR_RSSI_PEAK 4'h8
`define PSR_RSSI_CTIME 4'hc
`define PSR_RSSI_CLEN 4'hd
`define PSR_RSSI_ETIME 4'he

// two-bit page codes of 2Ch and 2Dh
`define PSR_PG_00 2'b00
`define PSR_PG_10 2'b10

// direct command opcodes
`define PSR_CMD_STORE_RSSI 8'ha8
`define PSR_CMD_ADC 8'h87

// interrupt status bits
`define PSR_IRQ_ADC 0
`define PSR_IRQ_NOISE 1
`define PSR_IRQ_COLL 2
`define PSR_IRQ_ERR 3
`define PSR_IRQ_RESET 4'h0

// gain-limit step ceiling
`define PSR_AGL_MAX 3'd4

// converter settle time, rounded up to whole clock cycles
`define PSR_CLOCK_NS 8
`define PSR_ADC_TIME_NS 20000
`define PSR_ADC_CYCLES ((`PSR_ADC_TIME_NS + `PSR_CLOCK_NS - 1) / `PSR_CLOCK_NS)

`endif

/* psr_pkg.sv */
// types shared by the paged status bank
`default_nettype none
package psr_pkg;

  // front-end measurement and event levels, all from outside this clock
  typedef struct packed {
    logic subc_phase;
    logic [2:0] agc_gain;
    logic iq_select;
    logic carrier_stable;
    logic pll_locked;
    logic osc_stable;
    logic [3:0] rssi_q;
    logic [3:0] rssi_i;
    logic [2:0] agl_q;
    logic [2:0] agl_i;
    logic [3:0] highpass_cal_value;
    logic [3:0] lowpass_cal_value;
    logic [7:0] adc_value;
    logic rx_active;
    logic tx_active;
    logic rx_bit;
    logic pilot_mark;
    logic data_mark;
    logic collision;
    logic proto_err;
  } psr_fe_t;

  // clamped gain-limit steps driven to the receiver
  typedef struct packed {
    logic [2:0] q_step;
    logic [2:0] i_step;
  } psr_agl_t;

  typedef enum logic [0:0] {
    PSR_ADC_IDLE = 1'b0,
    PSR_ADC_CONV = 1'b1
  } psr_adc_state_t;

endpackage
`default_nettype wire

/* paged_status_readout_test.sv */
// self-checking bench of the paged status readout bank
`default_nettype none
`include "psr_consts.svh"
module paged_status_readout_test;
  timeunit 1ns;
  timeprecision 1ps;
  import psr_pkg::*;

  // ****************************************
  // signals and design
  // ****************************************
  // short conversion keeps the run brief; timing below derives from it
  localparam int ADC_C = 40;
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack;
  logic adc_start;
  logic irq;
  psr_agl_t agl;
  psr_fe_t fe = '0;
  int err_total = 0;
  int n_compared = 0;
  int starts = 0;
  logic [7:0] rd;
  logic [7:0] rssi_exp [16] = '{8'hef, 8'h00, 8'hcd, 8'h00, 8'h56, 8'h00,
    8'ha4, 8'h00, 8'ha9, 8'h00, 8'h00, 8'h00, 8'h03, 8'h02, 8'h05, 8'h00};

  always #4 i_clock = ~i_clock;

  // count converter start pulses, sampled on the edge that takes them
  always @(posedge i_clock) begin
    if (adc_start === 1'b1) starts <= starts + 1;
  end

  psr_status_regs #(.ADC_CYCLES(ADC_C)) dut_u (
    .i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_fe(fe), .o_adc_start(adc_start), .o_agl(agl), .o_irq(irq)
  );

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input string name, input logic [7:0] seen,
      input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    if (err_total == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // one classic cycle; request held until ack is sampled high
  task automatic bus(input logic w, input logic [5:0] idx,
      input logic [7:0] wd);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h00_0000, wd};
    do begin
      @(posedge i_clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) err_total++;
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge i_clock);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
    bus(1'b1, idx, wd);
  endtask

  task automatic rchk(input logic [5:0] idx, input logic [7:0] exp,
      input string name);
    bus(1'b0, idx, 8'h00);
    check(name, rd, exp);
  endtask

  // front-end levels need two edges to cross, events three clocks each way
  task automatic settle();
    repeat (4) @(posedge i_clock);
  endtask

  task automatic rs(input logic [3:0] q, input logic [3:0] i);
    fe.rssi_q <= q;
    fe.rssi_i <= i;
    settle();
  endtask

  task automatic bits(input int n);
    repeat (n) begin
      fe.rx_bit <= 1'b1;
      settle();
      fe.rx_bit <= 1'b0;
      settle();
    end
  endtask

  initial begin
    repeat (20000) @(posedge i_clock);
    err_total++;
    test_done();
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge i_clock);
    i_reset_n <= 1'b1;
    rchk(`PSR_IDX_PAGE, 8'h00, "page reset");
    rchk(`PSR_IDX_IRQ_ST, 8'h00, "irq status reset");
    rchk(`PSR_IDX_IRQ_MASK, 8'h00, "irq mask reset");
    wr(`PSR_IDX_PAGE, 8'ha5);
    rchk(`PSR_IDX_PAGE, 8'ha5, "page readback");
    // a write without byte lane 0 must leave the register alone
    sel <= 4'he;
    wr(`PSR_IDX_PAGE, 8'h77);
    sel <= 4'hf;
    rchk(`PSR_IDX_PAGE, 8'ha5, "lane0 off write");
    wr(6'h3f, 8'hff);
    rchk(6'h3f, 8'h00, "unmapped");
    fe.subc_phase <= 1'b1;
    fe.agc_gain <= 3'h5;
    fe.iq_select <= 1'b1;
    fe.carrier_stable <= 1'b1;
    fe.osc_stable <= 1'b1;
    settle();
    rchk(`PSR_IDX_AGC, 8'hd5, "agc idle");
    wr(`PSR_IDX_AGC, 8'h00);
    rchk(`PSR_IDX_AGC, 8'hd5, "agc write");
    // noise snapshot must survive later changes of the live level
    rs(4'hc, 4'hd);
    wr(`PSR_IDX_CMD, `PSR_CMD_STORE_RSSI);
    rs(4'h1, 4'h2);
    wr(`PSR_IDX_PAGE, 8'h00);
    rchk(`PSR_IDX_RSSI, 8'h12, "live rssi");
    wr(`PSR_IDX_PAGE, 8'h02);
    rchk(`PSR_IDX_RSSI, 8'hcd, "noise rssi");
    rchk(`PSR_IDX_IRQ_ST, 8'h02, "noise event");
    wr(`PSR_IDX_IRQ_ST, 8'h02);
    // one reception: peak, pilot, data, collision and error timing
    rs(4'h3, 4'h9);
    fe.rx_active <= 1'b1;
    settle();
    fe.iq_select <= 1'b0;
    rs(4'h7, 4'h2);
    rs(4'h5, 4'h6);
    fe.pilot_mark <= 1'b1;
    settle();
    rs(4'ha, 4'h4);
    fe.data_mark <= 1'b1;
    settle();
    bits(3);
    fe.collision <= 1'b1;
    settle();
    bits(2);
    fe.collision <= 1'b0;
    settle();
    fe.proto_err <= 1'b1;
    settle();
    fe.rx_active <= 1'b0;
    fe.pilot_mark <= 1'b0;
    fe.data_mark <= 1'b0;
    fe.proto_err <= 1'b0;
    fe.pll_locked <= 1'b1;
    fe.carrier_stable <= 1'b0;
    rs(4'he, 4'hf);
    for (int k = 0; k < 16; k++) begin
      wr(`PSR_IDX_PAGE, {4'h0, 4'(k)});
      rchk(`PSR_IDX_RSSI, rssi_exp[k], "rssi page");
    end
    rchk(`PSR_IDX_AGC, 8'hdb, "agc after rx");
    rchk(`PSR_IDX_IRQ_ST, 8'h0c, "rx events");
    check("irq masked", {7'h00, irq}, 8'h00);
    wr(`PSR_IDX_IRQ_MASK, 8'h04);
    check("irq raised", {7'h00, irq}, 8'h01);
    wr(`PSR_IDX_IRQ_ST, 8'h04);
    rchk(`PSR_IDX_IRQ_ST, 8'h08, "irq clear");
    check("irq cleared", {7'h00, irq}, 8'h00);
    wr(`PSR_IDX_IRQ_ST, 8'h08);
    // gain-limit codes above the ceiling must clamp on the receiver side
    fe.agl_q <= 3'h6;
    fe.agl_i <= 3'h2;
    fe.highpass_cal_value <= 4'h9;
    fe.lowpass_cal_value <= 4'h3;
    settle();
    wr(`PSR_IDX_PAGE, 8'h00);
    rchk(`PSR_IDX_PG2C, 8'h32, "gain limit");
    check("agl clamp", {2'b00, agl}, 8'h22);
    wr(`PSR_IDX_PAGE, 8'h20);
    rchk(`PSR_IDX_PG2C, 8'h93, "calibration");
    wr(`PSR_IDX_PAGE, 8'h10);
    rchk(`PSR_IDX_PG2C, 8'h00, "2c page one");
    fe.adc_value <= 8'h5a;
    wr(`PSR_IDX_PAGE, 8'h40);
    rchk(`PSR_IDX_PG2D, 8'h00, "2d page one");
    wr(`PSR_IDX_PAGE, 8'h00);
    settle();
    // second start lands while busy and must be dropped
    wr(`PSR_IDX_CMD, `PSR_CMD_ADC);
    wr(`PSR_IDX_CMD, `PSR_CMD_ADC);
    repeat (ADC_C - 15) @(posedge i_clock);
    rchk(`PSR_IDX_PG2D, 8'h00, "adc early");
    rchk(`PSR_IDX_IRQ_ST, 8'h00, "adc busy");
    repeat (4) @(posedge i_clock);
    rchk(`PSR_IDX_PG2D, 8'h5a, "adc result");
    rchk(`PSR_IDX_IRQ_ST, 8'h01, "adc done");
    check("adc starts", starts[7:0], 8'h01);
    // clear taken on the very edge the result lands; the event must win
    wr(`PSR_IDX_IRQ_ST, 8'h01);
    wr(`PSR_IDX_CMD, `PSR_CMD_ADC);
    repeat (ADC_C - 3) @(posedge i_clock);
    wr(`PSR_IDX_IRQ_ST, 8'h01);
    rchk(`PSR_IDX_IRQ_ST, 8'h01, "set beats clear");
    test_done();
  end
endmodule
`default_nettype wire
